//--- logic/charger_status_fault_regs.sv
`timescale 1ns/1ps
module charger_status_fault_regs
	import status_regs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic [2:0] input_source_type,
	input  wire logic [1:0] charge_phase,
	input  wire logic       input_in_range,
	input  wire logic       input_poor,
	input  wire logic       thermal_reg_active,
	input  wire logic       min_system_reg_active,
	input  wire logic       watchdog_expired,
	input  wire logic       otg_overload,
	input  wire logic       input_overvoltage,
	input  wire logic       battery_too_low,
	input  wire logic [1:0] charge_fault_code,
	input  wire logic       battery_overvoltage,
	input  wire logic [2:0] thermistor_zone,
	input  wire logic       buck_mode,
	input  wire logic       good_input_attached,
	input  wire logic       input_voltage_limit_active,
	input  wire logic       input_current_limit_active,
	input  wire logic       direct_charge_enable,
	input  wire logic       const_voltage_near,
	input  wire logic       topoff_counting,
	input  wire logic       adaptor_overvoltage,
	input  wire logic       vlimit_event,
	input  wire logic       ilimit_event,
	output logic            interrupt_pulse_out,
	output logic            defaults_reload,
	output logic            safety_timer_reset
);
	typedef struct packed {
		logic [7:0] status_a;
		logic [7:0] status_b;
		logic [5:0] status_c;
		logic       vlimit_irq_mask;
		logic       ilimit_irq_mask;
		logic       reload_pending;
		logic [7:0] rdata;
		logic       irq;
		logic       reload_out;
		logic       timer_reset_out;
	} regs_state_type;

	regs_state_type state_r;
	regs_state_type state_nxt;

	// status_c keeps the six upper bits of the regulation byte
	localparam int C_BASE = ACOV_BIT;

	status_sample_if sif ();

	// fault byte passes one extra stage, so fault sources reach status_b one edge after the others
	status_stage fault_stage (
		.clk   (clk),
		.rst_n (rst_n),
		.sif   (sif)
	);

	logic [2:0] src_clean;
	logic [2:0] ntc_clean;
	logic       otg_fault;
	logic       wr_reload;

	always_comb begin
		src_clean = input_source_type;
		if (input_source_type == SRC_RESERVED) begin
			src_clean = SRC_NONE;
		end
		ntc_clean = thermistor_zone;
		if (thermistor_zone == NTC_RESERVED_1 || thermistor_zone == NTC_RESERVED_4 ||
				thermistor_zone == NTC_RESERVED_7) begin
			ntc_clean = NTC_NORMAL;
		end
		if (thermistor_zone == NTC_COOL && !buck_mode) begin
			ntc_clean = NTC_NORMAL;
		end
		otg_fault = otg_overload | input_overvoltage | battery_too_low;
		sif.raw = '0;
		sif.raw[WD_BIT] = watchdog_expired;
		sif.raw[OTG_BIT] = otg_fault;
		sif.raw[CF_MSB:CF_LSB] = charge_fault_code;
		sif.raw[BOV_BIT] = battery_overvoltage;
		sif.raw[NTC_MSB:NTC_LSB] = ntc_clean;
	end

	assign wr_reload = reg_wr && reg_addr == ADDR_IDENTITY && reg_wdata[RELOAD_BIT];

	always_comb begin
		state_nxt = state_r;
		// source code only; limit value is reported by the control bank
		state_nxt.status_a[SRC_MSB:SRC_LSB] = src_clean;
		state_nxt.status_a[PHASE_MSB:PHASE_LSB] = charge_phase;
		state_nxt.status_a[PG_BIT] = input_in_range & ~input_poor;
		state_nxt.status_a[THERM_BIT] = thermal_reg_active;
		state_nxt.status_a[VSYS_BIT] = min_system_reg_active;
		state_nxt.status_b = sif.held;
		state_nxt.status_c[GOOD_BIT - C_BASE] = good_input_attached;
		state_nxt.status_c[VLIM_BIT - C_BASE] = input_voltage_limit_active;
		state_nxt.status_c[ILIM_BIT - C_BASE] = input_current_limit_active;
		state_nxt.status_c[CV_BIT - C_BASE] = direct_charge_enable & const_voltage_near;
		state_nxt.status_c[TOPOFF_BIT - C_BASE] = topoff_counting;
		state_nxt.status_c[ACOV_BIT - C_BASE] = adaptor_overvoltage;

		// only mask bits and reload bit are writable
		if (reg_wr && reg_addr == ADDR_REG_STATUS) begin
			state_nxt.vlimit_irq_mask = reg_wdata[VMASK_BIT];
			state_nxt.ilimit_irq_mask = reg_wdata[IMASK_BIT];
		end

		// reload takes one cycle, then the bit drops by itself
		state_nxt.reload_out = 1'h0;
		state_nxt.timer_reset_out = 1'h0;
		state_nxt.reload_pending = 1'h0;
		if (state_r.reload_pending) begin
			state_nxt.vlimit_irq_mask = MASK_RESET;
			state_nxt.ilimit_irq_mask = MASK_RESET;
		end
		if (wr_reload) begin
			state_nxt.reload_pending = 1'h1;
			state_nxt.reload_out = 1'h1;
			state_nxt.timer_reset_out = 1'h1;
		end

		state_nxt.irq = (vlimit_event & ~state_r.vlimit_irq_mask) |
			(ilimit_event & ~state_r.ilimit_irq_mask);

		state_nxt.rdata = state_r.rdata;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_INPUT_CHARGE: state_nxt.rdata = state_r.status_a;
				ADDR_FAULT:        state_nxt.rdata = state_r.status_b;
				ADDR_REG_STATUS:   state_nxt.rdata = {state_r.status_c, state_r.vlimit_irq_mask,
					state_r.ilimit_irq_mask};
				ADDR_IDENTITY:     state_nxt.rdata = {state_r.reload_pending, PART_NUMBER_VAL,
					MAKER_PART_VAL, REVISION_VAL};
				default:           state_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata = state_r.rdata;
	assign interrupt_pulse_out = state_r.irq;
	assign defaults_reload = state_r.reload_out;
	assign safety_timer_reset = state_r.timer_reset_out;

	AST_VMASK: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r.vlimit_irq_mask && !ilimit_event) |=> !interrupt_pulse_out)
		else $error("voltage event pulse not masked");
	AST_IMASK: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r.ilimit_irq_mask && !vlimit_event) |=> !interrupt_pulse_out)
		else $error("current event pulse not masked");
	AST_VPASS: assert property (@(posedge clk) disable iff (!rst_n)
		(!state_r.vlimit_irq_mask && vlimit_event) |=> interrupt_pulse_out)
		else $error("unmasked voltage event lost");

	sequence reload_write_s;
		wr_reload;
	endsequence
	sequence reload_done_s;
		defaults_reload ##1 (!state_r.vlimit_irq_mask && !state_r.ilimit_irq_mask);
	endsequence
	sequence reload_pulse_s;
		defaults_reload && safety_timer_reset;
	endsequence
	AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
		reload_write_s |=> reload_pulse_s)
		else $error("reload pulse missing");
	AST_RELOAD_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		reload_write_s |=> reload_done_s)
		else $error("reload did not restore masks");
	AST_PG: assert property (@(posedge clk) disable iff (!rst_n)
		input_poor |=> !state_r.status_a[PG_BIT])
		else $error("power good set on poor input");
	AST_CV: assert property (@(posedge clk) disable iff (!rst_n)
		!direct_charge_enable |=> !state_r.status_c[CV_BIT - C_BASE])
		else $error("cv bit set without direct charge");
	AST_OTG: assert property (@(posedge clk) disable iff (!rst_n)
		otg_overload |=> ##1 state_r.status_b[OTG_BIT])
		else $error("boost fault not reported");
	AST_RO: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_FAULT && !watchdog_expired) |=> ##1 !state_r.status_b[WD_BIT])
		else $error("write reached read-only fault field");

	// pins reach status_a and status_c one edge late, the fault byte two
	sequence status_sampled_s;
		rst_n;
	endsequence
	sequence fault_sampled_s;
		rst_n ##1 rst_n;
	endsequence

	AST_SRC_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		(input_source_type != SRC_RESERVED) |=> state_r.status_a[SRC_MSB:SRC_LSB] == $past(input_source_type))
		else $error("source code not passed through");
	AST_SRC_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
		(input_source_type == SRC_RESERVED) |=> state_r.status_a[SRC_MSB:SRC_LSB] == SRC_NONE)
		else $error("reserved source code not reported as none");
	AST_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_a[PHASE_MSB:PHASE_LSB] == $past(charge_phase))
		else $error("charge phase not reported");

	AST_PG_GOOD: assert property (@(posedge clk) disable iff (!rst_n)
		(input_in_range && !input_poor) |=> state_r.status_a[PG_BIT])
		else $error("power good missing on good input");
	AST_PG_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		!input_in_range |=> !state_r.status_a[PG_BIT])
		else $error("power good set out of range");

	AST_THERM: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_a[THERM_BIT] == $past(thermal_reg_active))
		else $error("thermal regulation bit wrong");
	AST_VSYS: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_a[VSYS_BIT] == $past(min_system_reg_active))
		else $error("min system bit wrong");

	AST_WD: assert property (@(posedge clk) disable iff (!rst_n)
		fault_sampled_s |=> state_r.status_b[WD_BIT] == $past(watchdog_expired, 2))
		else $error("watchdog bit wrong");
	AST_OTG_ANY: assert property (@(posedge clk) disable iff (!rst_n)
		fault_sampled_s |=> state_r.status_b[OTG_BIT] == $past(otg_fault, 2))
		else $error("boost fault bit wrong");
	AST_OTG_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		(!otg_overload && !input_overvoltage && !battery_too_low) |=> ##1 !state_r.status_b[OTG_BIT])
		else $error("boost fault without cause");

	AST_CFAULT: assert property (@(posedge clk) disable iff (!rst_n)
		fault_sampled_s |=> state_r.status_b[CF_MSB:CF_LSB] == $past(charge_fault_code, 2))
		else $error("charge fault code wrong");
	AST_BOV: assert property (@(posedge clk) disable iff (!rst_n)
		fault_sampled_s |=> state_r.status_b[BOV_BIT] == $past(battery_overvoltage, 2))
		else $error("battery overvoltage bit wrong");

	AST_NTC_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
		(thermistor_zone == NTC_RESERVED_1 || thermistor_zone == NTC_RESERVED_4 ||
		thermistor_zone == NTC_RESERVED_7) |=> ##1 state_r.status_b[NTC_MSB:NTC_LSB] == NTC_NORMAL)
		else $error("reserved zone code not reported as normal");
	AST_NTC_COOL: assert property (@(posedge clk) disable iff (!rst_n)
		(thermistor_zone == NTC_COOL && !buck_mode) |=> ##1 state_r.status_b[NTC_MSB:NTC_LSB] == NTC_NORMAL)
		else $error("cool zone reported outside buck mode");
	AST_NTC_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
		fault_sampled_s |=> state_r.status_b[NTC_MSB:NTC_LSB] == $past(ntc_clean, 2))
		else $error("zone field not tracking");

	AST_GOOD: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_c[GOOD_BIT - C_BASE] == $past(good_input_attached))
		else $error("good input bit wrong");
	AST_VLIM: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_c[VLIM_BIT - C_BASE] == $past(input_voltage_limit_active))
		else $error("voltage limit bit wrong");
	AST_ILIM: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_c[ILIM_BIT - C_BASE] == $past(input_current_limit_active))
		else $error("current limit bit wrong");

	AST_CV_ON: assert property (@(posedge clk) disable iff (!rst_n)
		(direct_charge_enable && const_voltage_near) |=> state_r.status_c[CV_BIT - C_BASE])
		else $error("cv bit missing with direct charge");
	AST_TOPOFF: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_c[TOPOFF_BIT - C_BASE] == $past(topoff_counting))
		else $error("topoff bit wrong");
	AST_ACOV: assert property (@(posedge clk) disable iff (!rst_n)
		status_sampled_s |=> state_r.status_c[ACOV_BIT - C_BASE] == $past(adaptor_overvoltage))
		else $error("adaptor overvoltage bit wrong");

	AST_IPASS: assert property (@(posedge clk) disable iff (!rst_n)
		(!state_r.ilimit_irq_mask && ilimit_event) |=> interrupt_pulse_out)
		else $error("unmasked current event lost");
	AST_IRQ_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		(!vlimit_event && !ilimit_event) |=> !interrupt_pulse_out)
		else $error("pulse without event");

	AST_MASK_WR: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_REG_STATUS && !state_r.reload_pending) |=>
		(state_r.vlimit_irq_mask == $past(reg_wdata[VMASK_BIT]) && state_r.ilimit_irq_mask == $past(reg_wdata[IMASK_BIT])))
		else $error("mask write lost");
	AST_MASK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(!(reg_wr && reg_addr == ADDR_REG_STATUS) && !state_r.reload_pending) |=>
		$stable({state_r.vlimit_irq_mask, state_r.ilimit_irq_mask}))
		else $error("masks changed without write");

	AST_RELOAD_SELF: assert property (@(posedge clk) disable iff (!rst_n)
		(reload_write_s ##1 !wr_reload) |=> (!defaults_reload && !state_r.reload_pending))
		else $error("reload bit did not clear");
	AST_RELOAD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_IDENTITY && !reg_wdata[RELOAD_BIT]) |=> !state_r.reload_pending)
		else $error("reload started by zero write");
	AST_TIMER_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_reload |=> !safety_timer_reset)
		else $error("timer reset without reload");

	AST_RD_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_INPUT_CHARGE) |=> reg_rdata == $past(state_r.status_a))
		else $error("status read wrong");
	AST_RD_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_FAULT) |=> reg_rdata == $past(state_r.status_b))
		else $error("fault read wrong");
	AST_RD_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_REG_STATUS) |=> reg_rdata[VMASK_BIT] == $past(state_r.vlimit_irq_mask))
		else $error("mask read wrong");

	AST_RD_ID: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_IDENTITY) |=> (reg_rdata[PART_MSB:PART_LSB] == PART_NUMBER_VAL &&
		reg_rdata[MAKER_BIT] == MAKER_PART_VAL && reg_rdata[REV_MSB:REV_LSB] == REVISION_VAL))
		else $error("identity read wrong");
	AST_RD_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_IDENTITY) |=> reg_rdata[RELOAD_BIT] == $past(state_r.reload_pending))
		else $error("reload bit read wrong");
	AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr != ADDR_INPUT_CHARGE && reg_addr != ADDR_FAULT &&
		reg_addr != ADDR_REG_STATUS && reg_addr != ADDR_IDENTITY) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without read");
endmodule

//--- logic/status_regs_pkg.sv
package status_regs_pkg;
	localparam logic [7:0] ADDR_INPUT_CHARGE = 8'h08;
	localparam logic [7:0] ADDR_FAULT        = 8'h09;
	localparam logic [7:0] ADDR_REG_STATUS   = 8'h0A;
	localparam logic [7:0] ADDR_IDENTITY     = 8'h0B;

	localparam int SRC_MSB    = 7;
	localparam int SRC_LSB    = 5;
	localparam int PHASE_MSB  = 4;
	localparam int PHASE_LSB  = 3;
	localparam int PG_BIT     = 2;
	localparam int THERM_BIT  = 1;
	localparam int VSYS_BIT   = 0;
	localparam int WD_BIT     = 7;
	localparam int OTG_BIT    = 6;
	localparam int CF_MSB     = 5;
	localparam int CF_LSB     = 4;
	localparam int BOV_BIT    = 3;
	localparam int NTC_MSB    = 2;
	localparam int NTC_LSB    = 0;
	localparam int GOOD_BIT   = 7;
	localparam int VLIM_BIT   = 6;
	localparam int ILIM_BIT   = 5;
	localparam int CV_BIT     = 4;
	localparam int TOPOFF_BIT = 3;
	localparam int ACOV_BIT   = 2;
	localparam int VMASK_BIT  = 1;
	localparam int IMASK_BIT  = 0;
	localparam int RELOAD_BIT = 7;
	localparam int PART_MSB   = 6;
	localparam int PART_LSB   = 3;
	localparam int MAKER_BIT  = 2;
	localparam int REV_MSB    = 1;
	localparam int REV_LSB    = 0;

	// arbitrary identity values
	localparam logic [3:0] PART_NUMBER_VAL = 4'h5;
	localparam logic       MAKER_PART_VAL  = 1'h0;
	localparam logic [1:0] REVISION_VAL    = 2'h1;

	localparam logic       MASK_RESET      = 1'h0;
	localparam logic [2:0] SRC_NONE        = 3'h0;
	localparam logic [2:0] SRC_RESERVED    = 3'h4;
	localparam logic [2:0] NTC_RESERVED_1  = 3'h1;
	localparam logic [2:0] NTC_RESERVED_4  = 3'h4;
	localparam logic [2:0] NTC_RESERVED_7  = 3'h7;
	localparam logic [2:0] NTC_COOL        = 3'h3;
	localparam logic [2:0] NTC_NORMAL      = 3'h0;
endpackage

//--- logic/status_sample_if.sv
`timescale 1ns/1ps
interface status_sample_if;
	logic [7:0] raw;
	logic [7:0] held;
	modport owner (output raw, input held);
	modport stage (input raw, output held);
endinterface

//--- logic/status_stage.sv
`timescale 1ns/1ps
module status_stage (
	input  wire logic clk,
	input  wire logic rst_n,
	status_sample_if.stage sif
);
	typedef struct packed {
		logic [7:0] held;
	} stage_state_type;

	stage_state_type state_r;
	stage_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.held = sif.raw;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sif.held = state_r.held;
endmodule

//--- verification/charger_status_fault_regs_tb.sv
`timescale 1ns/1ps
module charger_status_fault_regs_tb;
	import status_regs_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [26:0] st = '0;
	logic        vlimit_event = 1'b0;
	logic        ilimit_event = 1'b0;
	logic        interrupt_pulse_out;
	logic        defaults_reload;
	logic        safety_timer_reset;
	logic [31:0] rs = 32'h2E77;
	logic [1:0]  m = 2'h0;
	logic [7:0]  w;
	logic [2:0]  z;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;

	charger_status_fault_regs u_charger_status_fault_regs (
		.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.input_source_type(st[2:0]), .charge_phase(st[4:3]), .input_in_range(st[5]), .input_poor(st[6]),
		.thermal_reg_active(st[7]), .min_system_reg_active(st[8]), .watchdog_expired(st[9]),
		.otg_overload(st[10]), .input_overvoltage(st[11]), .battery_too_low(st[12]),
		.charge_fault_code(st[14:13]), .battery_overvoltage(st[15]), .thermistor_zone(st[18:16]),
		.buck_mode(st[19]), .good_input_attached(st[20]), .input_voltage_limit_active(st[21]),
		.input_current_limit_active(st[22]), .direct_charge_enable(st[23]), .const_voltage_near(st[24]),
		.topoff_counting(st[25]), .adaptor_overvoltage(st[26]), .vlimit_event, .ilimit_event,
		.interrupt_pulse_out, .defaults_reload, .safety_timer_reset
	);

	always #2 clk = ~clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// reserved zone codes and cool outside buck mode read as normal
	function automatic logic [2:0] zone_exp(input logic [2:0] c, input logic buck);
		if (c == 3'h1 || c == 3'h4 || c == 3'h7 || (c == 3'h3 && !buck))
			return 3'h0;
		return c;
	endfunction

	task automatic complete_run();
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		@(posedge clk);
		#1 chk8(reg_rdata, exp);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		chk8(reg_rdata, 8'h00);
		chk1(defaults_reload, 1'b0);
		for (int i = 0; i < 40; i++) begin
			rs = lfsr_next(rs);
			st = rs[26:0];
			// first passes sweep every source and zone code
			if (i < 8) begin
				st[2:0] = i[2:0];
				st[18:16] = i[2:0];
			end
			rs = lfsr_next(rs);
			w = rs[7:0];
			wr(8'h0A, w);
			m = w[1:0];
			wr(8'h08, ~w);
			wr(8'h09, w);
			wr(8'h0B, w & 8'h7F);
			chk1(defaults_reload, 1'b0);
			if (i % 5 == 4) begin
				wr(8'h0B, 8'h80);
				chk1(defaults_reload, 1'b1);
				chk1(safety_timer_reset, 1'b1);
				m = 2'h0;
				@(posedge clk);
				#1 chk1(defaults_reload, 1'b0);
			end
			vlimit_event = rs[9];
			ilimit_event = rs[10];
			@(posedge clk);
			#1 chk1(interrupt_pulse_out, (rs[9] & ~m[1]) | (rs[10] & ~m[0]));
			vlimit_event = 1'b0;
			ilimit_event = 1'b0;
			z = zone_exp(st[18:16], st[19]);
			rd(8'h08, {(st[2:0] == 3'h4) ? 3'h0 : st[2:0], st[4:3], st[5] & ~st[6], st[7], st[8]});
			rd(8'h09, {st[9], st[10] | st[11] | st[12], st[14:13], st[15], z});
			rd(8'h0A, {st[20], st[21], st[22], st[23] & st[24], st[25], st[26], m});
			rd(8'h0B, {1'b0, PART_NUMBER_VAL, MAKER_PART_VAL, REVISION_VAL});
			rd(8'h0C, 8'h00);
		end
		complete_run();
	end
endmodule
